// file: verilog/memmap_consts.svh
// constants of the banked memory map: pc, file offsets, bus indices
// assumes inclusion by bare name from each design file
`ifndef MEMMAP_CONSTS_SVH
`define MEMMAP_CONSTS_SVH
`define PC_W          13
`define PC_RST_VEC    13'h0000
`define PC_IRQ_VEC    13'h0004
`define PC_SMALL_MASK 13'h0fff
`define PC_ONE        13'h0001
`define PCH_W         5
`define FA_W          9
`define OFS_W         7
`define OFS_INDIRECT  7'h00
`define OFS_PC_LOW    7'h02
`define OFS_FLAGS     7'h03
`define OFS_POINTER   7'h04
`define OFS_PC_HIGH   7'h0a
`define OFS_INTR      7'h0b
`define OFS_XGP       7'h10
`define OFS_GP        7'h20
`define OFS_SHARED    7'h70
`define GP_DEPTH      352
`define SF_DEPTH      128
`define GP_B1         9'h060
`define GP_B2         9'h0b0
`define GP_B3         9'h100
`define GP_SH         9'h050
`define BIT_BSEL_LO   5
`define BIT_BSEL_HI   6
`define BIT_IND_HI    7
`define BIT_STEP      0
`define BIT_IRQ       1
`define BIT_LARGE     0
`define BIT_SZ_LO     1
`define BIT_SZ_HI     2
`define WB_ADR_W      12
`define IDX_W         10
`define IDX_PC        10'h080
`define IDX_CTRL      10'h081
`define IDX_VARIANT   10'h082
`define IDX_FETCH     10'h083
`define BYTE_ZERO     8'h00
`define WORD_ZERO     32'h0000_0000
`endif

// file: verilog/memmap_pkg.sv
// types shared by the memory map decoder files
// assumes no other package
`default_nettype none
package memmap_pkg;
  typedef enum logic [1:0] {BUS_IDLE = 2'h1, BUS_ACK = 2'h2} bus_state_e;
  typedef enum logic [1:0] {GP_256 = 2'h0, GP_352 = 2'h1, GP_336 = 2'h2} gp_size_e;
  typedef enum logic [3:0] {
    LOC_NONE    = 4'h0,
    LOC_IND     = 4'h1,
    LOC_PC_LOW  = 4'h2,
    LOC_FLAGS   = 4'h3,
    LOC_POINTER = 4'h4,
    LOC_PC_HIGH = 4'h5,
    LOC_INTR    = 4'h6,
    LOC_SF      = 4'h7,
    LOC_GP      = 4'h8
  } loc_kind_e;
endpackage
`default_nettype wire

// file: verilog/file_addr_decode.sv
// decodes a 9-bit file address into location kind and store index
// assumes a combinational caller; size code 3 acts as the 256 variant
`include "memmap_consts.svh"
`default_nettype none
module file_addr_decode (
  input  wire logic [`FA_W-1:0]         faddr_i,
  input  wire memmap_pkg::gp_size_e     gp_size_i,
  output memmap_pkg::loc_kind_e         kind_o,
  output logic [`FA_W-1:0]              gp_idx_o,
  output logic [`OFS_W-1:0]             sf_idx_o
);
  logic [1:0]       bank;
  logic [`OFS_W-1:0] ofs;
  logic [`FA_W-1:0] ofs9;
  assign bank = faddr_i[`FA_W-1:`OFS_W];
  assign ofs = faddr_i[`OFS_W-1:0];
  assign ofs9 = {2'h0, ofs};
  assign sf_idx_o = {bank, ofs[4:0]};
  always_comb begin
    kind_o = memmap_pkg::LOC_NONE;
    gp_idx_o = '0;
    if (ofs >= `OFS_SHARED) begin
      kind_o = memmap_pkg::LOC_GP;
      gp_idx_o = `GP_SH + ofs9 - {2'h0, `OFS_SHARED};
    end else if (ofs >= `OFS_GP) begin
      case (bank)
        2'h0: begin
          kind_o = memmap_pkg::LOC_GP;
          gp_idx_o = ofs9 - {2'h0, `OFS_GP};
        end
        2'h1: begin
          kind_o = memmap_pkg::LOC_GP;
          gp_idx_o = `GP_B1 + ofs9 - {2'h0, `OFS_GP};
        end
        2'h2: begin
          kind_o = memmap_pkg::LOC_GP;
          gp_idx_o = `GP_B2 + ofs9 - {2'h0, `OFS_GP};
        end
        default: begin
          if (gp_size_i == memmap_pkg::GP_352) begin
            kind_o = memmap_pkg::LOC_GP;
            gp_idx_o = `GP_B3 + ofs9 - {2'h0, `OFS_XGP};
          end else if (gp_size_i == memmap_pkg::GP_336) begin
            kind_o = memmap_pkg::LOC_GP;
            gp_idx_o = `GP_B3 + ofs9 - {2'h0, `OFS_GP};
          end
        end
      endcase
    end else if (bank == 2'h3 && gp_size_i == memmap_pkg::GP_352 && ofs >= `OFS_XGP) begin
      kind_o = memmap_pkg::LOC_GP;
      gp_idx_o = `GP_B3 + ofs9 - {2'h0, `OFS_XGP};
    end else begin
      case (ofs)
        `OFS_INDIRECT: kind_o = memmap_pkg::LOC_IND;
        `OFS_PC_LOW:   kind_o = memmap_pkg::LOC_PC_LOW;
        `OFS_FLAGS:    kind_o = memmap_pkg::LOC_FLAGS;
        `OFS_POINTER:  kind_o = memmap_pkg::LOC_POINTER;
        `OFS_PC_HIGH:  kind_o = memmap_pkg::LOC_PC_HIGH;
        `OFS_INTR:     kind_o = memmap_pkg::LOC_INTR;
        default:       kind_o = memmap_pkg::LOC_SF;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verilog/pc_unit.sv
// 13-bit program counter with reset and interrupt vectors and fetch wrap
// assumes load, irq and step are one-cycle pulses qualified by ce_i
`include "memmap_consts.svh"
`default_nettype none
module pc_unit (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic             load_i,
  input  wire logic [`PC_W-1:0] load_val_i,
  input  wire logic             irq_i,
  input  wire logic             step_i,
  input  wire logic             large_i,
  output logic      [`PC_W-1:0] pc_o,
  output logic      [`PC_W-1:0] fetch_o
);
  logic [`PC_W-1:0] next_pc;
  logic             after_rst;
  always_comb begin
    next_pc = pc_o;
    if (load_i) begin
      next_pc = load_val_i;
    end else if (irq_i) begin
      next_pc = `PC_IRQ_VEC;
    end else if (step_i) begin
      next_pc = pc_o + `PC_ONE;
    end
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_o <= `PC_RST_VEC;
    end else if (ce_i) begin
      pc_o <= next_pc;
    end
  end
  // small variant folds every address into the first 4K words
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_o <= `PC_RST_VEC;
    end else if (ce_i) begin
      fetch_o <= large_i ? next_pc : (next_pc & `PC_SMALL_MASK);
    end
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      after_rst <= 1'b1;
    end else if (ce_i) begin
      after_rst <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  reset_vector_a: assert property (after_rst |-> pc_o == `PC_RST_VEC)
    else $error("pc not at reset vector after reset");
  irq_vector_a: assert property (ce_i && irq_i && !load_i |=> pc_o == `PC_IRQ_VEC)
    else $error("interrupt did not reach its vector");
  fetch_wrap_a: assert property (ce_i |=>
      fetch_o == ($past(large_i) ? pc_o : (pc_o & `PC_SMALL_MASK)))
    else $error("fetch address not wrapped for small variant");
  pc_step_a: assert property (ce_i && step_i && !load_i && !irq_i |=>
      pc_o == $past(pc_o) + `PC_ONE)
    else $error("pc step wrong");
  irq_seen_c: cover property (ce_i && irq_i ##1 ce_i && step_i);
endmodule
`default_nettype wire

// file: verilog/banked_memory_map_decoder.sv
// banked data memory map and program counter behind a wishbone slave
// assumes classic wishbone, one clock, byte data in lane 0 for file accesses
//
// Local design decision: the Wishbone interface to the registers.
`include "memmap_consts.svh"
`default_nettype none
module banked_memory_map_decoder (
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic      [`PC_W-1:0]     pc_o,
  output logic      [`PC_W-1:0]     fetch_addr_o,
  output logic                      bank_select_high_o,
  output logic                      bank_select_low_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------

  memmap_pkg::bus_state_e state;
  logic [7:0]             core_flags;
  logic [7:0]             indirect_pointer;
  logic [7:0]             pc_high_latch;
  logic [7:0]             intr_control;
  logic [7:0]             variant;
  logic [7:0]             special_function_store [0:`SF_DEPTH-1];
  logic [7:0]             general_purpose_store [0:`GP_DEPTH-1];

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------

  logic [`IDX_W-1:0]     idx;
  logic                  req;
  logic                  wr;
  logic [7:0]            wd;
  logic                  file_hit;
  logic [`FA_W-1:0]      req_faddr;
  logic [`FA_W-1:0]      ind_faddr;
  memmap_pkg::gp_size_e  gp_size;
  memmap_pkg::loc_kind_e req_kind;
  memmap_pkg::loc_kind_e ind_kind;
  memmap_pkg::loc_kind_e kind;
  logic [`FA_W-1:0]      req_gidx;
  logic [`FA_W-1:0]      ind_gidx;
  logic [`FA_W-1:0]      gidx;
  logic [`OFS_W-1:0]     req_sidx;
  logic [`OFS_W-1:0]     ind_sidx;
  logic [`OFS_W-1:0]     sidx;

  assign idx = wb_adr_i[`WB_ADR_W-1:2];
  assign req = ce_i && wb_cyc_i && wb_stb_i && state == memmap_pkg::BUS_IDLE;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wd = wb_dat_i[7:0];
  assign gp_size = memmap_pkg::gp_size_e'(variant[`BIT_SZ_HI:`BIT_SZ_LO]);
  assign ind_faddr = {core_flags[`BIT_IND_HI], indirect_pointer};

  // low window uses the bank bits, the upper window names the bank itself
  always_comb begin
    file_hit = 1'b0;
    req_faddr = {core_flags[`BIT_BSEL_HI], core_flags[`BIT_BSEL_LO], idx[`OFS_W-1:0]};
    if (idx[`IDX_W-1]) begin
      file_hit = 1'b1;
      req_faddr = idx[`FA_W-1:0];
    end else if (idx < `IDX_PC) begin
      file_hit = 1'b1;
    end
  end

  file_addr_decode u_dec_req (
    .faddr_i   (req_faddr),
    .gp_size_i (gp_size),
    .kind_o    (req_kind),
    .gp_idx_o  (req_gidx),
    .sf_idx_o  (req_sidx)
  );

  file_addr_decode u_dec_ind (
    .faddr_i   (ind_faddr),
    .gp_size_i (gp_size),
    .kind_o    (ind_kind),
    .gp_idx_o  (ind_gidx),
    .sf_idx_o  (ind_sidx)
  );

  // a pointer aimed at the indirect port itself finds nothing, reads zero
  always_comb begin
    kind = memmap_pkg::LOC_NONE;
    gidx = req_gidx;
    sidx = req_sidx;
    if (file_hit) begin
      kind = req_kind;
      if (req_kind == memmap_pkg::LOC_IND) begin
        kind = (ind_kind == memmap_pkg::LOC_IND) ? memmap_pkg::LOC_NONE : ind_kind;
        gidx = ind_gidx;
        sidx = ind_sidx;
      end
    end
  end

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------

  logic             pc_load;
  logic [`PC_W-1:0] pc_load_val;
  logic             pc_irq;
  logic             pc_step;
  logic             ctrl_wr;

  assign ctrl_wr = wr && !file_hit && idx == `IDX_CTRL;
  assign pc_irq = ctrl_wr && wb_dat_i[`BIT_IRQ];
  assign pc_step = ctrl_wr && wb_dat_i[`BIT_STEP];

  // writing the low byte jumps, taking the upper bits from the latch
  always_comb begin
    pc_load = 1'b0;
    pc_load_val = {pc_high_latch[`PCH_W-1:0], wd};
    if (wr && kind == memmap_pkg::LOC_PC_LOW) begin
      pc_load = 1'b1;
    end else if (req && wb_we_i && !file_hit && idx == `IDX_PC && wb_sel_i[1:0] == 2'h3) begin
      pc_load = 1'b1;
      pc_load_val = wb_dat_i[`PC_W-1:0];
    end
  end

  pc_unit u_pc (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .load_i     (pc_load),
    .load_val_i (pc_load_val),
    .irq_i      (pc_irq),
    .step_i     (pc_step),
    .large_i    (variant[`BIT_LARGE]),
    .pc_o       (pc_o),
    .fetch_o    (fetch_addr_o)
  );

  // ---------------------------------------------------------------
  // core registers, one physical copy behind every bank alias
  // ---------------------------------------------------------------

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_flags <= `BYTE_ZERO;
    end else if (wr && kind == memmap_pkg::LOC_FLAGS) begin
      core_flags <= wd;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      indirect_pointer <= `BYTE_ZERO;
    end else if (wr && kind == memmap_pkg::LOC_POINTER) begin
      indirect_pointer <= wd;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_high_latch <= `BYTE_ZERO;
    end else if (wr && kind == memmap_pkg::LOC_PC_HIGH) begin
      pc_high_latch <= wd;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      intr_control <= `BYTE_ZERO;
    end else if (wr && kind == memmap_pkg::LOC_INTR) begin
      intr_control <= wd;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      variant <= `BYTE_ZERO;
    end else if (wr && !file_hit && idx == `IDX_VARIANT) begin
      variant <= wd;
    end
  end

  assign bank_select_high_o = core_flags[`BIT_BSEL_HI];
  assign bank_select_low_o = core_flags[`BIT_BSEL_LO];

  // ---------------------------------------------------------------
  // static stores; no reset, contents are undefined until written
  // ---------------------------------------------------------------

  always_ff @(posedge sys_clk_i) begin
    if (wr && kind == memmap_pkg::LOC_SF) begin
      special_function_store[sidx] <= wd;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr && kind == memmap_pkg::LOC_GP) begin
      general_purpose_store[gidx] <= wd;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  logic [7:0]  rd_file;
  logic [31:0] rd_word;

  always_comb begin
    case (kind)
      memmap_pkg::LOC_PC_LOW:  rd_file = pc_o[7:0];
      memmap_pkg::LOC_FLAGS:   rd_file = core_flags;
      memmap_pkg::LOC_POINTER: rd_file = indirect_pointer;
      memmap_pkg::LOC_PC_HIGH: rd_file = pc_high_latch;
      memmap_pkg::LOC_INTR:    rd_file = intr_control;
      memmap_pkg::LOC_SF:      rd_file = special_function_store[sidx];
      memmap_pkg::LOC_GP:      rd_file = general_purpose_store[gidx];
      default:                 rd_file = `BYTE_ZERO;
    endcase
  end

  // control word reads zero: its bits are one-shot commands
  always_comb begin
    rd_word = `WORD_ZERO;
    if (file_hit) begin
      rd_word = {24'h00_0000, rd_file};
    end else begin
      case (idx)
        `IDX_PC:      rd_word = {19'h0_0000, pc_o};
        `IDX_VARIANT: rd_word = {24'h00_0000, variant};
        `IDX_FETCH:   rd_word = {19'h0_0000, fetch_addr_o};
        default:      rd_word = `WORD_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // wishbone handshake: ack one cycle after the strobe is seen
  // ---------------------------------------------------------------

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= memmap_pkg::BUS_IDLE;
    end else if (ce_i) begin
      case (state)
        memmap_pkg::BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            state <= memmap_pkg::BUS_ACK;
          end
        end
        memmap_pkg::BUS_ACK: state <= memmap_pkg::BUS_IDLE;
        default:             state <= memmap_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_dat_o <= `WORD_ZERO;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ack may only fall where the enable lets it, so the drop is checked under ce
  ack_timing_a: assert property (req ##1 ce_i |-> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  bank_select_a: assert property (file_hit && !idx[`IDX_W-1] |->
      req_faddr[`FA_W-1:`OFS_W] == {bank_select_high_o, bank_select_low_o})
    else $error("direct access used the wrong bank");
  core_mirror_a: assert property (req_faddr[`OFS_W-1:0] == `OFS_FLAGS |->
      req_kind == memmap_pkg::LOC_FLAGS)
    else $error("core register not mirrored in this bank");
  shared_top_a: assert property (req_faddr[`OFS_W-1:0] >= `OFS_SHARED |->
      req_kind == memmap_pkg::LOC_GP &&
      req_gidx == `GP_SH + {2'h0, req_faddr[`OFS_W-1:0]} - {2'h0, `OFS_SHARED})
    else $error("shared top region not common to all banks");
  low_special_a: assert property (req_faddr[`OFS_W-1:0] < `OFS_GP &&
      req_faddr[`FA_W-1:`OFS_W] != 2'h3 |-> req_kind != memmap_pkg::LOC_GP)
    else $error("low offset decoded as general storage");
  unimpl_zero_a: assert property (req && !wb_we_i && file_hit &&
      kind == memmap_pkg::LOC_NONE |=> wb_dat_o == `WORD_ZERO)
    else $error("unimplemented location did not read zero");
  indirect_path_a: assert property (file_hit && req_kind == memmap_pkg::LOC_IND &&
      ind_kind == memmap_pkg::LOC_GP |-> kind == memmap_pkg::LOC_GP && gidx == ind_gidx)
    else $error("indirect access missed the pointed location");
  core_write_a: assert property (wr && kind == memmap_pkg::LOC_POINTER |=>
      indirect_pointer == $past(wb_dat_i[7:0]) ##1 indirect_pointer == $past(wb_dat_i[7:0], 2))
    else $error("pointer register did not keep written value");
  low_jump_a: assert property (wr && kind == memmap_pkg::LOC_PC_LOW |=>
      pc_o == {$past(pc_high_latch[`PCH_W-1:0]), $past(wb_dat_i[7:0])})
    else $error("low byte write did not jump");

  gp_write_c: cover property (wr && kind == memmap_pkg::LOC_GP);
  indirect_read_c: cover property (req && !wb_we_i && req_kind == memmap_pkg::LOC_IND);
  shared_alias_c: cover property (req && req_faddr[`FA_W-1:`OFS_W] == 2'h3 &&
      req_faddr[`OFS_W-1:0] >= `OFS_SHARED);

endmodule
`default_nettype wire

// file: testbench/core_bus_model.sv
// bus side of the execution core: classic wishbone master issuing single cycles
// assumes a slave that answers with a one-cycle ack; the bench bounds every wait
`default_nettype none
module core_bus_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [11:0] adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] lost = 32'h0000_0000;
  // an ack with no cycle open breaks the single-cycle handshake
  always @(posedge clk_i) begin
    if (ack_i === 1'b1 && cyc_o !== 1'b1) begin
      lost++;
    end
  end
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 12'h000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  // ------------------------------------------------------------
  // one transfer, held until ack is sampled high
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    sel_o <= 4'h0;
    // released address and data lines show inverted values so stale data is never mistaken for valid
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// file: testbench/banked_memory_map_decoder_tb.sv
// self-checking bench for the banked memory map decoder
// assumes the core bus model as wishbone master and a 20 MHz clock
`default_nettype none
module banked_memory_map_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [8:0] wa;
    logic [7:0] wd;
    logic [8:0] ra;
    logic [7:0] ex;
  } row_s;
  // ------------------------------------------------------------
  // write a file address, read another, expect a byte
  // ------------------------------------------------------------
  localparam row_s ROWS [10] = '{
    '{9'h020, 8'h5a, 9'h020, 8'h5a}, '{9'h0f0, 8'h3c, 9'h070, 8'h3c},
    '{9'h170, 8'h77, 9'h1f0, 8'h77}, '{9'h104, 8'h21, 9'h184, 8'h21},
    '{9'h08b, 8'h81, 9'h00b, 8'h81}, '{9'h185, 8'h99, 9'h185, 8'h99},
    '{9'h1a0, 8'h55, 9'h1a0, 8'h00}, '{9'h004, 8'h20, 9'h000, 8'h5a},
    '{9'h080, 8'hc3, 9'h020, 8'hc3}, '{9'h004, 8'h00, 9'h100, 8'h00}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce  = 1'b1;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [12:0] pc;
  logic [12:0] fetch;
  logic        bsel_hi;
  logic        bsel_lo;
  int          err_count = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  core_bus_model core (.clk_i(clk), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  banked_memory_map_decoder uut (.sys_clk_i(clk), .sys_rst_i(rst), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pc_o(pc), .fetch_addr_o(fetch),
    .bank_select_high_o(bsel_hi), .bank_select_low_o(bsel_lo));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] fa(input logic [8:0] f);
    fa = 12'h800 | {1'b0, f, 2'b00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    core.xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    core.xfer(1'b0, a, 32'h0000_0000, q);
    check(q, e);
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({19'h0_0000, pc}, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      wr(fa(ROWS[i].wa), {24'h00_0000, ROWS[i].wd});
      rdchk(fa(ROWS[i].ra), {24'h00_0000, ROWS[i].ex});
    end
    $display("rows done");
    for (int b = 0; b < 4; b++) begin
      wr(fa(9'h003), {25'h000_0000, b[1:0], 5'h00});
      @(posedge clk);
      check({30'h0000_0000, bsel_hi, bsel_lo}, 32'(b));
      wr(12'h040, 32'h0000_0040 + 32'(b));
      rdchk(fa({b[1:0], 7'h10}), 32'h0000_0040 + 32'(b));
      rdchk(12'h00c, {25'h000_0000, b[1:0], 5'h00});
      wr(12'h1fc, 32'h0000_00a0 + 32'(b));
      rdchk(fa(9'h07f), 32'h0000_00a0 + 32'(b));
    end
    $display("banks done");
    wr(12'h200, 32'h0000_0fff);
    wr(12'h204, 32'h0000_0001);
    rdchk(12'h20c, 32'h0000_0000);
    check({19'h0_0000, fetch}, 32'h0000_0000);
    wr(12'h208, 32'h0000_0001);
    rdchk(12'h20c, 32'h0000_1000);
    check({19'h0_0000, fetch}, 32'h0000_1000);
    wr(12'h200, 32'h0000_1fff);
    wr(12'h204, 32'h0000_0001);
    rdchk(12'h200, 32'h0000_0000);
    wr(12'h204, 32'h0000_0003);
    rdchk(12'h200, 32'h0000_0004);
    wr(fa(9'h00a), 32'h0000_0015);
    wr(fa(9'h002), 32'h0000_0034);
    rdchk(12'h200, 32'h0000_1534);
    rdchk(fa(9'h182), 32'h0000_0034);
    wr(12'h208, 32'h0000_0002);
    wr(fa(9'h1a0), 32'h0000_0066);
    rdchk(fa(9'h1a0), 32'h0000_0066);
    wr(12'h208, 32'h0000_0004);
    wr(fa(9'h1a0), 32'h0000_003e);
    rdchk(fa(9'h190), 32'h0000_0043);
    wr(12'h208, 32'h0000_0002);
    rdchk(fa(9'h190), 32'h0000_003e);
    wr(12'h210, 32'h0000_00ff);
    rdchk(12'h210, 32'h0000_0000);
    $display("pc and variants done");
    // a request made while the enable is low must wait, then land intact
    ce <= 1'b0;
    fork
      wr(fa(9'h021), 32'h0000_00e7);
      begin
        repeat (4) @(posedge clk);
        check({31'h0000_0000, ack}, 32'h0000_0000);
        ce <= 1'b1;
      end
    join
    rdchk(fa(9'h021), 32'h0000_00e7);
    $display("freeze done");
    wr(fa(9'h003), 32'h0000_0060);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({17'h0_0000, bsel_hi, bsel_lo, pc}, 32'h0000_0000);
    rst <= 1'b0;
    rdchk(12'h200, 32'h0000_0000);
    check(core.lost, 32'h0000_0000);
    $display("reset done");
    summarize();
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
